// ===== input_terminal_function_mux.sv
module input_terminal_function_mux
  import terminal_mux_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  // clock and reset
  input  wire logic                     aclk,
  input  wire logic                     aresetn,
  // axi4-lite write address
  input  wire logic [ADDR_W-1:0]        s_axi_awaddr,
  input  wire logic                     s_axi_awvalid,
  output logic                          s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0]              s_axi_wdata,
  input  wire logic [3:0]               s_axi_wstrb,
  input  wire logic                     s_axi_wvalid,
  output logic                          s_axi_wready,
  // axi4-lite write response
  output logic [1:0]                    s_axi_bresp,
  output logic                          s_axi_bvalid,
  input  wire logic                     s_axi_bready,
  // axi4-lite read address
  input  wire logic [ADDR_W-1:0]        s_axi_araddr,
  input  wire logic                     s_axi_arvalid,
  output logic                          s_axi_arready,
  // axi4-lite read data
  output logic [31:0]                   s_axi_rdata,
  output logic [1:0]                    s_axi_rresp,
  output logic                          s_axi_rvalid,
  input  wire logic                     s_axi_rready,
  // contact inputs, low when closed to common
  input  wire logic [NUM_TERMINALS-1:0] terminal_n,
  input  wire logic                     forward_start_input_n,
  input  wire logic                     reverse_start_input_n,
  // drive state
  input  wire logic                     drive_stopped,
  // decoded functions
  output logic                          analog_current_select,
  output logic                          speed_high_select,
  output logic                          speed_middle_select,
  output logic                          speed_low_select,
  output logic                          external_thermal_trip,
  output logic                          output_inhibit,
  output logic                          second_set_select,
  output logic                          fifteen_speed_select,
  output logic                          flux_vector_mode,
  output logic                          run_command,
  output logic                          run_reverse
);

  // digit test helper: one bit set for every terminal carrying a function code
  function automatic logic [NUM_TERMINALS-1:0] match_code(input logic [ALLOC_W-1:0] alloc,
                                                          input logic [DIGIT_W-1:0] code);
    logic [NUM_TERMINALS-1:0] hit;
    hit = '0;
    for (int i = 0; i < NUM_TERMINALS; i++) begin
      hit[i] = (alloc[i*DIGIT_W +: DIGIT_W] == code);
    end
    return hit;
  endfunction : match_code

  // software-visible settings
  logic [ALLOC_W-1:0] input_allocation_setting;
  logic [15:0]        control_method_setting;
  logic               thermal_input_select_setting;
  logic               current_input_select_setting;
  logic               second_accel_time_setting;
  logic               flux_request_sw;

  // synchronised terminals
  logic [NUM_TERMINALS-1:0] term_active;
  logic [1:0]               start_active;

  terminal_sync #(
    .WIDTH(NUM_TERMINALS + 2)
  ) u_sync (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .contact_n ({reverse_start_input_n, forward_start_input_n, terminal_n}),
    .active    ({start_active, term_active})
  );

  wire legacy_mode = (input_allocation_setting == ALLOC_DEFAULT);

  wire [NUM_TERMINALS-1:0] hit_current = match_code(input_allocation_setting, FN_CURRENT_SEL);
  wire [NUM_TERMINALS-1:0] hit_high    = match_code(input_allocation_setting, FN_SPEED_HIGH);
  wire [NUM_TERMINALS-1:0] hit_middle  = match_code(input_allocation_setting, FN_SPEED_MIDDLE);
  wire [NUM_TERMINALS-1:0] hit_low     = match_code(input_allocation_setting, FN_SPEED_LOW);
  wire [NUM_TERMINALS-1:0] hit_thermal = match_code(input_allocation_setting, FN_THERMAL);
  wire [NUM_TERMINALS-1:0] hit_hold    = match_code(input_allocation_setting, FN_SELF_HOLD);
  wire [NUM_TERMINALS-1:0] hit_inhibit = match_code(input_allocation_setting, FN_OUTPUT_INHIBIT);
  wire [NUM_TERMINALS-1:0] hit_second  = match_code(input_allocation_setting, FN_SECOND_SET);
  wire [NUM_TERMINALS-1:0] hit_defer   = match_code(input_allocation_setting, FN_SECOND_DEFER);
  wire [NUM_TERMINALS-1:0] hit_fifteen = match_code(input_allocation_setting, FN_FIFTEEN_SPEED);

  wire alloc_current = |(hit_current & term_active);
  wire alloc_high    = |(hit_high & term_active);
  wire alloc_middle  = |(hit_middle & term_active);
  wire alloc_low     = |(hit_low & term_active);
  wire alloc_thermal = |(hit_thermal & term_active);
  wire alloc_inhibit = |(hit_inhibit & term_active);
  wire alloc_second  = |((hit_second | hit_defer) & term_active);
  wire alloc_fifteen = |(hit_fifteen & term_active);
  wire hold_assigned = !legacy_mode && (|hit_hold);
  wire hold_closed   = |(hit_hold & term_active);
  wire defer_mode    = !legacy_mode && (|hit_defer);

  // legacy map: terminal 0 low/thermal, 1 middle/current, 2 high, 3 inhibit/second
  wire leg_low     = term_active[0] && !thermal_input_select_setting;
  wire leg_thermal = term_active[0] && thermal_input_select_setting;
  wire leg_middle  = term_active[1] && !current_input_select_setting;
  wire leg_current = term_active[1] && current_input_select_setting;
  wire leg_high    = term_active[2];
  wire leg_inhibit = term_active[3] && !second_accel_time_setting;
  wire leg_second  = term_active[3] && second_accel_time_setting;

  // legacy selects only count in legacy mode
  wire next_current = legacy_mode ? leg_current : alloc_current;
  wire next_high    = legacy_mode ? leg_high    : alloc_high;
  wire next_middle  = legacy_mode ? leg_middle  : alloc_middle;
  wire next_low     = legacy_mode ? leg_low     : alloc_low;
  wire next_thermal = legacy_mode ? leg_thermal : alloc_thermal;
  wire next_inhibit = legacy_mode ? leg_inhibit : alloc_inhibit;
  wire next_second  = legacy_mode ? leg_second  : alloc_second;
  wire next_fifteen = legacy_mode ? 1'b0        : alloc_fifteen;

  // terminal-driven mode choice only at switchable code
  wire switchable = (control_method_setting == CTRL_SWITCHABLE);
  wire next_flux_target = switchable ? next_second : flux_request_sw;
  // deferred mode change under digit 8 waits for stop
  wire mode_may_change = !(switchable && defer_mode) || drive_stopped;

  // start direction from the two start inputs; both closed means no start
  wire fwd_req = start_active[0] && !start_active[1];
  wire rev_req = start_active[1] && !start_active[0];
  wire start_req = fwd_req || rev_req;

  // run state
  typedef enum logic [1:0] {RUN_IDLE, RUN_LATCHED} run_state_t;
  run_state_t run_state;
  run_state_t next_run_state;
  logic       latched_reverse;

  always_comb begin
    next_run_state = run_state;
    case (run_state)
      RUN_IDLE: begin
        if (hold_assigned && hold_closed && start_req) begin
          next_run_state = RUN_LATCHED;
        end
      end
      RUN_LATCHED: begin
        if (!hold_assigned || !hold_closed) begin
          next_run_state = RUN_IDLE;
        end
      end
      default: begin
        next_run_state = RUN_IDLE;
      end
    endcase
  end

  // without self-hold run follows the start inputs directly
  wire next_run = hold_assigned ? (next_run_state == RUN_LATCHED) : start_req;
  wire next_rev = hold_assigned ? ((run_state == RUN_IDLE) ? rev_req : latched_reverse)
                                : rev_req;

  // run latch and direction memory
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      run_state       <= RUN_IDLE;
      latched_reverse <= 1'b0;
    end else begin
      run_state <= next_run_state;
      if (run_state == RUN_IDLE) begin
        latched_reverse <= rev_req;
      end
    end
  end

  // function outputs registered
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      analog_current_select <= 1'b0;
      speed_high_select     <= 1'b0;
      speed_middle_select   <= 1'b0;
      speed_low_select      <= 1'b0;
      external_thermal_trip <= 1'b0;
      output_inhibit        <= 1'b0;
      fifteen_speed_select  <= 1'b0;
      run_command           <= 1'b0;
      run_reverse           <= 1'b0;
    end else begin
      analog_current_select <= next_current;
      speed_high_select     <= next_high;
      speed_middle_select   <= next_middle;
      speed_low_select      <= next_low;
      external_thermal_trip <= next_thermal;
      output_inhibit        <= next_inhibit;
      fifteen_speed_select  <= next_fifteen;
      run_command           <= next_run;
      run_reverse           <= next_rev;
    end
  end

  // second set follows input at once; mode waits for stop only under digit 8
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      second_set_select <= 1'b0;
      flux_vector_mode  <= 1'b0;
    end else begin
      second_set_select <= next_second;
      if (mode_may_change) begin
        flux_vector_mode <= next_flux_target;
      end
    end
  end

  // display digits, with bit 16 set when the leading digit is zero
  wire [3:0] lead_digit  = input_allocation_setting[ALLOC_W-1 -: DIGIT_W];
  wire       lead_blank  = (lead_digit == FN_CURRENT_SEL);
  wire [31:0] display_word = {15'h0000, lead_blank, input_allocation_setting};

  // bus handshake: aw and w taken independently, response after both
  logic              aw_held;
  logic              w_held;
  logic [ADDR_W-1:0] aw_addr;
  logic [31:0]       w_data;
  logic [3:0]        w_strb;
  wire do_write = aw_held && w_held && !s_axi_bvalid;

  // digits above nine are refused so the word stays valid decimal
  wire digits_ok = (w_data[3:0] <= DIGIT_MAX) && (w_data[7:4] <= DIGIT_MAX) &&
                   (w_data[11:8] <= DIGIT_MAX) && (w_data[15:12] <= DIGIT_MAX);
  wire sel_alloc  = (aw_addr[7:0] == OFS_ALLOCATION);
  wire sel_legacy = (aw_addr[7:0] == OFS_LEGACY);
  wire sel_ctrl   = (aw_addr[7:0] == OFS_CONTROL);
  wire wr_ok      = (sel_alloc && digits_ok && (&w_strb[1:0])) || sel_legacy || sel_ctrl;

  // write channel capture and response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      aw_addr       <= '0;
      w_data        <= '0;
      w_strb        <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
    end else begin
      s_axi_awready <= !aw_held && !s_axi_awready && s_axi_awvalid;
      s_axi_wready  <= !w_held && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // settings registers; allocation word written whole
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      input_allocation_setting     <= ALLOC_DEFAULT;
      control_method_setting       <= 16'h0000;
      flux_request_sw              <= 1'b0;
      thermal_input_select_setting <= 1'b0;
      current_input_select_setting <= 1'b0;
      second_accel_time_setting    <= 1'b0;
    end else if (do_write && wr_ok) begin
      if (sel_alloc) begin
        input_allocation_setting <= w_data[ALLOC_W-1:0];
      end
      if (sel_legacy && w_strb[0]) begin
        thermal_input_select_setting <= w_data[LEG_THERMAL_BIT];
        current_input_select_setting <= w_data[LEG_CURRENT_BIT];
        second_accel_time_setting    <= w_data[LEG_ACCEL_BIT];
      end
      if (sel_ctrl && (&w_strb[1:0])) begin
        control_method_setting <= w_data[CTL_METHOD_LSB +: 16];
      end
      if (sel_ctrl && w_strb[2]) begin
        flux_request_sw <= w_data[CTL_FLUX_BIT];
      end
    end
  end

  // read mux
  wire [31:0] status_word = {18'h00000, run_reverse, second_set_select, flux_vector_mode,
                             run_command, 6'h00, term_active};
  wire [31:0] legacy_word = {29'h00000000, second_accel_time_setting,
                             current_input_select_setting, thermal_input_select_setting};
  wire [31:0] ctrl_word   = {14'h0000, drive_stopped, flux_request_sw, control_method_setting};
  wire [7:0]  raddr       = s_axi_araddr[7:0];
  wire        rd_hit      = (raddr == OFS_ALLOCATION) || (raddr == OFS_LEGACY) ||
                            (raddr == OFS_CONTROL) || (raddr == OFS_STATUS) ||
                            (raddr == OFS_DISPLAY);
  wire [31:0] rd_value    = (raddr == OFS_ALLOCATION) ? {16'h0000, input_allocation_setting} :
                            (raddr == OFS_LEGACY)     ? legacy_word :
                            (raddr == OFS_CONTROL)    ? ctrl_word :
                            (raddr == OFS_STATUS)     ? status_word :
                            (raddr == OFS_DISPLAY)    ? display_word : 32'h00000000;

  // read channel: one-cycle arready, data next cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_value;
        s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule : input_terminal_function_mux

// ===== terminal_mux_pkg.sv
package terminal_mux_pkg;
  // count of assignable terminals, bits per decimal digit and width of the allocation word
  localparam int          NUM_TERMINALS      = 4;
  localparam int          DIGIT_W            = 4;
  localparam int          ALLOC_W            = 16;
  // register map offsets (byte addresses)
  localparam logic [7:0]  OFS_ALLOCATION     = 8'h00;
  localparam logic [7:0]  OFS_LEGACY         = 8'h04;
  localparam logic [7:0]  OFS_CONTROL        = 8'h08;
  localparam logic [7:0]  OFS_STATUS         = 8'h0C;
  localparam logic [7:0]  OFS_DISPLAY        = 8'h10;
  // allocation word is held as four packed BCD digits
  localparam logic [15:0] ALLOC_DEFAULT      = 16'h9999;
  localparam logic [3:0]  DIGIT_MAX          = 4'h9;
  // digit function codes
  localparam logic [3:0]  FN_CURRENT_SEL     = 4'h0;
  localparam logic [3:0]  FN_SPEED_HIGH      = 4'h1;
  localparam logic [3:0]  FN_SPEED_MIDDLE    = 4'h2;
  localparam logic [3:0]  FN_SPEED_LOW       = 4'h3;
  localparam logic [3:0]  FN_THERMAL         = 4'h4;
  localparam logic [3:0]  FN_SELF_HOLD       = 4'h5;
  localparam logic [3:0]  FN_OUTPUT_INHIBIT  = 4'h6;
  localparam logic [3:0]  FN_SECOND_SET      = 4'h7;
  localparam logic [3:0]  FN_SECOND_DEFER    = 4'h8;
  localparam logic [3:0]  FN_FIFTEEN_SPEED   = 4'h9;
  // control method setting: switchable code
  localparam logic [15:0] CTRL_SWITCHABLE    = 16'h9999;
  // legacy register fields
  localparam int          LEG_THERMAL_BIT    = 0;
  localparam int          LEG_CURRENT_BIT    = 1;
  localparam int          LEG_ACCEL_BIT      = 2;
  // control register fields
  localparam int          CTL_METHOD_LSB     = 0;
  localparam int          CTL_FLUX_BIT       = 16;
  localparam int          CTL_STOPPED_BIT    = 17;
  // status register fields
  localparam int          ST_FUNC_LSB        = 0;
  localparam int          ST_RUN_BIT         = 10;
  localparam int          ST_FLUX_BIT        = 11;
  localparam int          ST_SECOND_BIT      = 12;
  localparam int          ST_DIR_BIT         = 13;
  // axi response codes
  localparam logic [1:0]  RESP_OKAY          = 2'b00;
  localparam logic [1:0]  RESP_SLVERR        = 2'b10;
endpackage : terminal_mux_pkg

// ===== terminal_sync.sv
// two-stage synchroniser with active-low contact conversion
module terminal_sync
  import terminal_mux_pkg::*;
#(
  parameter int WIDTH = 4
) (
  // clock and reset
  input  wire logic             aclk,
  input  wire logic             aresetn,
  // contacts: low means closed to common
  input  wire logic [WIDTH-1:0] contact_n,
  // synchronised active-high view
  output logic      [WIDTH-1:0] active
);
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;

  // first stage feeds only the second; idle contacts reset as open
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stage1 <= '1;
      stage2 <= '1;
    end else begin
      stage1 <= contact_n;
      stage2 <= stage1;
    end
  end

  assign active = ~stage2;
endmodule : terminal_sync

// ===== mux_checker.sv
module mux_checker
  import terminal_mux_pkg::*;
(
  // clock and reset
  input wire logic                     aclk,
  input wire logic                     aresetn,
  // bus handshakes
  input wire logic                     s_axi_awvalid,
  input wire logic                     s_axi_awready,
  input wire logic                     s_axi_bvalid,
  input wire logic                     s_axi_bready,
  input wire logic                     s_axi_arvalid,
  input wire logic                     s_axi_arready,
  input wire logic                     s_axi_rvalid,
  input wire logic                     s_axi_rready,
  input wire logic [1:0]               s_axi_rresp,
  input wire logic [31:0]              s_axi_rdata,
  // contacts and decoded functions
  input wire logic [NUM_TERMINALS-1:0] terminal_n,
  input wire logic                     forward_start_input_n,
  input wire logic                     reverse_start_input_n,
  input wire logic                     speed_high_select,
  input wire logic                     speed_low_select,
  input wire logic                     output_inhibit,
  input wire logic                     second_set_select,
  input wire logic                     run_command
);
  timeunit 1ns;
  timeprecision 1ps;
  // one domain, so clock and reset are given once
  default clocking @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // bus rules: responses stand until taken, ready pulses, bounded replies, empty error reads, quiet reset
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped early");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
    else $error("read data dropped early");
  aw_pulse_a: assert property (s_axi_awready |=> !s_axi_awready)
    else $error("write address ready held");
  r_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  b_bound_a: assert property (s_axi_awvalid && s_axi_awready |-> ##[1:4] s_axi_bvalid)
    else $error("write response missing");
  err_data_a: assert property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR |-> s_axi_rdata == 32'h0)
    else $error("error read carries data");
  reset_quiet_a: assert property (disable iff (1'b0) !aresetn |=> !s_axi_bvalid && !run_command)
    else $error("outputs live in reset");
  // with all four contacts open, high, low, inhibit and second stay off, whatever the map
  open_idle_a: assert property ((terminal_n == 4'hF)[*5] |->
    !(speed_high_select || speed_low_select || output_inhibit || second_set_select))
    else $error("function active with open contacts");
  no_start_a: assert property ((forward_start_input_n && reverse_start_input_n)[*5]
    ##0 !run_command |=> !run_command)
    else $error("run without start");

  c_err_c: cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
  c_stop_c: cover property ($fell(run_command));
  c_second_c: cover property (second_set_select);
endmodule : mux_checker

bind input_terminal_function_mux mux_checker i_mux_checker (
  .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rresp,
  .s_axi_rdata, .terminal_n, .forward_start_input_n, .reverse_start_input_n,
  .speed_high_select, .speed_low_select, .output_inhibit, .second_set_select,
  .run_command
);

// ===== contact_bank.sv
module contact_bank
  import terminal_mux_pkg::*;
(
  // closures asked for by the bench
  input  wire logic [NUM_TERMINALS-1:0] close_term,
  input  wire logic                     close_fwd,
  input  wire logic                     close_rev,
  // contact lines with pull-ups
  output logic      [NUM_TERMINALS-1:0] terminal_n,
  output logic                          fwd_n,
  output logic                          rev_n
);
  timeunit 1ns;
  timeprecision 1ps;
  // an open contact floats to its pull-up, never to its last value
  assign terminal_n = ~close_term;
  assign fwd_n      = ~close_fwd;
  assign rev_n      = ~close_rev;
endmodule : contact_bank

// ===== testbench.sv
module testbench
  import terminal_mux_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, close_fwd, close_rev, fwd_n, rev_n;
  logic        drive_stopped, flux, run, rev_dir;
  logic [1:0]  bresp, rresp;
  logic [2:0]  lg;
  logic [3:0]  close_term, term_n, act;
  logic [7:0]  awaddr, araddr, fn;
  logic [15:0] al;
  logic [31:0] wdata, rdata, r;
  logic [31:0] seed = 32'h00003756;
  int          miscompares = 0;
  int          n_checks = 0;
  int          pos [10] = '{7, 6, 5, 4, 3, -1, 2, 1, 1, 0};

  input_terminal_function_mux i_input_terminal_function_mux (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .terminal_n(term_n), .forward_start_input_n(fwd_n), .reverse_start_input_n(rev_n),
    .drive_stopped(drive_stopped), .analog_current_select(fn[7]),
    .speed_high_select(fn[6]), .speed_middle_select(fn[5]), .speed_low_select(fn[4]),
    .external_thermal_trip(fn[3]), .output_inhibit(fn[2]), .second_set_select(fn[1]),
    .fifteen_speed_select(fn[0]), .flux_vector_mode(flux), .run_command(run),
    .run_reverse(rev_dir));
  contact_bank i_contact_bank (.close_term(close_term), .close_fwd(close_fwd),
    .close_rev(close_rev), .terminal_n(term_n), .fwd_n(fwd_n), .rev_n(rev_n));

  // expected function vector from allocation, legacy selects and closed contacts
  function automatic logic [7:0] model(logic [15:0] a, logic [2:0] l, logic [3:0] c);
    logic [7:0] f;
    f = 8'h00;
    if (a == ALLOC_DEFAULT) begin
      f[l[0] ? 3 : 4] = c[0];
      f[l[1] ? 7 : 5] = c[1];
      f[6] = c[2];
      f[l[2] ? 1 : 2] = c[3];
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (pos[a[4*i +: 4]] >= 0) f[pos[a[4*i +: 4]]] |= c[i];
      end
    end
    return f;
  endfunction : model

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  task automatic chk_v(input logic [7:0] g, input logic [7:0] e);
    n_checks++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %0t outputs %h expected %h", $time, g, e);
    end
  endtask : chk_v

  task automatic chk_b(input logic [33:0] g, input logic [33:0] e);
    n_checks++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %0t bus %h expected %h", $time, g, e);
    end
  endtask : chk_b

  // bus master: hold each channel until its ready, keep bready until bvalid
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    chk_b({32'h0, bresp}, {32'h0, er});
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
    chk_b({rdata, rresp}, {ed, er});
  endtask : rd

  // contacts pass a synchroniser, so give them a few edges
  task automatic wt(input int n);
    repeat (n) @(posedge aclk);
  endtask : wt

  task automatic stop_test();
    if (miscompares == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : stop_test

  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end

  // far more than the sequence needs
  initial begin
    repeat (6000) @(posedge aclk);
    miscompares++;
    stop_test();
  end

  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, close_fwd, close_rev} = 8'h00;
    {awaddr, araddr, wdata, close_term, drive_stopped} = 53'h0;
    wt(4);
    aresetn <= 1'b1;
    rd(OFS_ALLOCATION, 32'h0000_9999, RESP_OKAY);
    rd(OFS_LEGACY, 32'h0, RESP_OKAY);
    rd(8'h20, 32'h0, RESP_SLVERR);
    wr(OFS_ALLOCATION, 32'h0000_00A1, RESP_SLVERR);
    rd(OFS_ALLOCATION, 32'h0000_9999, RESP_OKAY);
    wr(OFS_ALLOCATION, 32'h0000_0123, RESP_OKAY);
    rd(OFS_DISPLAY, 32'h0001_0123, RESP_OKAY);
    // same code on all terminals, one contact closed
    for (int c = 0; c < 10; c++) begin
      al = {4{4'(c)}};
      act = 4'(1 << (c % 4));
      wr(OFS_ALLOCATION, {16'h0, al}, RESP_OKAY);
      close_term <= act;
      wt(5);
      chk_v(fn, model(al, 3'h0, act));
    end
    // self-hold on terminal 0
    wr(OFS_ALLOCATION, 32'h0000_0005, RESP_OKAY);
    close_term <= 4'h1;
    close_fwd  <= 1'b1;
    wt(5);
    chk_v({6'h0, rev_dir, run}, 8'h01);
    close_fwd <= 1'b0;
    wt(5);
    chk_v({6'h0, rev_dir, run}, 8'h01);
    rd(OFS_STATUS, 32'h0000_0401, RESP_OKAY);
    close_term <= 4'h0;
    wt(5);
    chk_v({7'h0, run}, 8'h00);
    close_term <= 4'h1;
    close_rev  <= 1'b1;
    wt(5);
    chk_v({6'h0, rev_dir, run}, 8'h03);
    close_rev  <= 1'b0;
    close_term <= 4'h0;
    // without self-hold both starts mean stop
    wr(OFS_ALLOCATION, 32'h0000_9999, RESP_OKAY);
    close_fwd <= 1'b1;
    wt(5);
    chk_v({6'h0, rev_dir, run}, 8'h01);
    close_rev <= 1'b1;
    wt(5);
    chk_v({7'h0, run}, 8'h00);
    {close_fwd, close_rev} <= 2'b00;
    // deferred mode switch with code 8, immediate with code 7
    wr(OFS_CONTROL, 32'h0000_9999, RESP_OKAY);
    wr(OFS_ALLOCATION, 32'h0000_0008, RESP_OKAY);
    close_term <= 4'h1;
    wt(5);
    chk_v({6'h0, fn[1], flux}, 8'h02);
    drive_stopped <= 1'b1;
    wt(5);
    chk_v({6'h0, fn[1], flux}, 8'h03);
    wr(OFS_ALLOCATION, 32'h0000_0007, RESP_OKAY);
    drive_stopped <= 1'b0;
    close_term    <= 4'h0;
    wt(5);
    chk_v({6'h0, fn[1], flux}, 8'h00);
    // random maps, legacy selects and contacts
    for (int k = 0; k < 24; k++) begin
      r = rnd();
      for (int i = 0; i < 4; i++) al[4*i +: 4] = 4'(r[8*i +: 8] % 10);
      if (k % 4 == 0) al = ALLOC_DEFAULT;
      lg = r[2:0] ^ r[13:11];
      act = r[7:4] ^ r[19:16];
      wr(OFS_ALLOCATION, {16'h0, al}, RESP_OKAY);
      wr(OFS_LEGACY, {29'h0, lg}, RESP_OKAY);
      close_term <= act;
      wt(5);
      chk_v(fn, model(al, lg, act));
    end
    stop_test();
  end
endmodule : testbench
